// *** shared/disp_host_pkg.sv ***
package disp_host_pkg;

  // ==========================================================
  // Register map of the controller (byte addresses)
  // ==========================================================
  localparam int AXI_AW = 8;                   // Address width
  localparam logic [7:0] OFS_CMD = 8'h00;      // Serial word launch
  localparam logic [7:0] OFS_STATUS = 8'h04;   // State and refusal flag
  localparam logic [7:0] OFS_CTRL = 8'h08;     // Pixel port enable
  localparam logic [7:0] OFS_COLOR = 8'h0C;    // Fill colour
  localparam int CMD_SEL_BIT = 8;              // Parameter select bit
  localparam int ST_REFUSED_BIT = 4;           // Sticky refusal bit
  localparam logic [1:0] RESP_OKAY = 2'h0;     // AXI OKAY
  localparam logic [1:0] RESP_SLVERR = 2'h2;   // AXI SLVERR

  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [7:0] SLEEP_ENTER_CMD = 8'h10;
  localparam logic [7:0] SLEEP_EXIT_CMD = 8'h11;
  localparam logic [7:0] GAMMA_CURVE_SELECT_CMD = 8'h26;
  localparam logic [7:0] DISPLAY_OFF_CMD = 8'h28;
  localparam logic [7:0] DISPLAY_ON_CMD = 8'h29;
  localparam logic [7:0] COLUMN_WINDOW_CMD = 8'h2A;
  localparam logic [7:0] ROW_WINDOW_CMD = 8'h2B;
  localparam logic [7:0] GAMMA_CURVE_VALUE = 8'h01;
  localparam logic [4:0] WINDOW_LAST_IDX = 5'h03;

  // Parameter bytes that follow each command code
  function automatic logic [4:0] param_count(input logic [7:0] code);
    case (code)
      8'h26, 8'h36, 8'h3A, 8'h5B, 8'h70, 8'h8A: param_count = 5'h01;
      8'hCC, 8'hCD, 8'hCE, 8'hD0, 8'hF0, 8'hF1: param_count = 5'h01;
      8'h2A, 8'h2B: param_count = 5'h04;
      8'hB0: param_count = 5'h14;
      8'hB1: param_count = 5'h13;
      8'hB2: param_count = 5'h06;
      8'hB8: param_count = 5'h03;
      8'hC0, 8'hC1: param_count = 5'h0D;
      default: param_count = 5'h00;
    endcase
  endfunction

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_HZ = 10_000_000;          // clk_sys rate
  localparam int SETTLE_MS = 200;              // Supply settle after exit
  localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int SCLK_HALF_CYC = 4;            // Serial clock half period
  localparam int PCLK_HALF_CYC = 4;            // Pixel clock half period
  localparam int PIX_PER_LINE = 240;           // Pixels in active line
  localparam int ROWS_PER_FRAME = 400;         // Active lines per frame
  localparam int LINE_SYNC_CYC = 4;            // Line sync, in pixels
  localparam int LINE_BP_CYC = 8;
  localparam int LINE_FP_CYC = 8;
  localparam int FRAME_SYNC_LINES = 2;         // Frame sync, in lines
  localparam int FRAME_BP_LINES = 4;
  localparam int FRAME_FP_LINES = 4;
  localparam int SER_WORD_BITS = 9;            // Select bit plus byte

  // ==========================================================
  // Carriers and state
  // ==========================================================
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdata;
  } serial_link_t;

  typedef struct packed {
    logic pclk;
    logic hsync_n;
    logic vsync_n;
    logic de;
    logic [17:0] data;
  } pixel_port_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic video_en;
    logic [17:0] color;
    serial_link_t link;
    logic ser_busy;
    logic [8:0] sh;
    logic [3:0] bits_left;
    logic [3:0] sdiv;
    logic [7:0] cur_cmd;
    logic [4:0] params_left;
    logic [4:0] param_idx;
    logic [23:0] win;
    logic sleeping;
    logic disp_on;
    logic [21:0] settle;
    logic refused;
    pixel_port_t pix;
    logic [3:0] pdiv;
    logic [9:0] hcnt;
    logic [9:0] vcnt;
  } state_t;

  localparam state_t ST_RESET = '{awready: 1'b1, wready: 1'b1,
    arready: 1'b1, sleeping: 1'b1,
    link: '{cs_n: 1'b1, sclk: 1'b0, sdata: 1'b0},
    pix: '{pclk: 1'b0, hsync_n: 1'b1, vsync_n: 1'b1, de: 1'b0,
           data: 18'h00000},
    default: '0};

endpackage

// *** verilog/disp_host_ctrl.sv ***
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module disp_host_ctrl #(
  parameter int SETTLE_CYC = disp_host_pkg::SETTLE_CYC,
  parameter int SCLK_HALF = disp_host_pkg::SCLK_HALF_CYC,
  parameter int PCLK_HALF = disp_host_pkg::PCLK_HALF_CYC,
  parameter int LINE_SYNC = disp_host_pkg::LINE_SYNC_CYC,
  parameter int LINE_BP = disp_host_pkg::LINE_BP_CYC,
  parameter int LINE_FP = disp_host_pkg::LINE_FP_CYC,
  parameter int FRAME_SYNC = disp_host_pkg::FRAME_SYNC_LINES,
  parameter int FRAME_BP = disp_host_pkg::FRAME_BP_LINES,
  parameter int FRAME_FP = disp_host_pkg::FRAME_FP_LINES,
  parameter int ROWS = disp_host_pkg::ROWS_PER_FRAME
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [disp_host_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [disp_host_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output disp_host_pkg::serial_link_t serial_link,
  output disp_host_pkg::pixel_port_t pixel_port
);
  import disp_host_pkg::*;

  // ==========================================================
  // Derived line and frame totals
  // ==========================================================
  localparam int H_ACT0 = LINE_SYNC + LINE_BP;     // First active pixel
  localparam int H_ACT1 = H_ACT0 + PIX_PER_LINE;   // Past last pixel
  localparam int H_TOT = H_ACT1 + LINE_FP;
  localparam int V_ACT0 = FRAME_SYNC + FRAME_BP;
  localparam int V_ACT1 = V_ACT0 + ROWS;
  localparam int V_TOT = V_ACT1 + FRAME_FP;

  state_t q;              // Registered state
  state_t d;              // Next state
  logic [31:0] wmask;     // Byte-lane mask of the pending write
  logic [31:0] wr_val;    // Masked write value for plain registers
  logic [8:0] word;       // Serial word asked for by software
  logic ok;               // Serial word passes the host checks
  logic [9:0] nh;         // Next line position
  logic [9:0] nv;         // Next frame line
  logic hact;             // Next position in active pixels
  logic vact;             // Next line in active lines

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb
  begin
    d = q;
    wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
             {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    wr_val = q.wdata & wmask;
    word = q.wdata[8:0];
    ok = 1'b0;
    nh = 10'h000;
    nv = 10'h000;
    hact = 1'b0;
    vact = 1'b0;

    // Settle countdown after sleep-exit
    if (q.settle != 22'h000000)
    begin
      d.settle = q.settle - 22'h000001;
    end

    // Write address and data, taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.awaddr = s_axi_awaddr;
      d.aw_got = 1'b1;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
      d.w_got = 1'b1;
      d.wready = 1'b0;
    end

    // Perform the write once both halves are held
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.awaddr)
        OFS_CMD:
        begin
          // Host checks before a word goes on the wire
          if (!q.wstrb[0] || !q.wstrb[1] || q.ser_busy)
          begin
            ok = 1'b0;
          end
          else if (!word[CMD_SEL_BIT])
          begin
            ok = 1'b1;
            if (word[7:0] == SLEEP_ENTER_CMD && q.disp_on)
            begin
              ok = 1'b0;
            end
            if (word[7:0] == DISPLAY_ON_CMD &&
                (q.sleeping || q.settle != 22'h000000))
            begin
              ok = 1'b0;
            end
          end
          else
          begin
            ok = (q.params_left != 5'h00);
            if (q.cur_cmd == GAMMA_CURVE_SELECT_CMD &&
                word[7:0] != GAMMA_CURVE_VALUE)
            begin
              ok = 1'b0;
            end
            if ((q.cur_cmd == COLUMN_WINDOW_CMD ||
                 q.cur_cmd == ROW_WINDOW_CMD) &&
                q.param_idx == WINDOW_LAST_IDX &&
                q.win[23:8] >= {q.win[7:0], word[7:0]})
            begin
              ok = 1'b0;
            end
          end
          d.refused = q.refused | !ok;
          if (ok)
          begin
            // Launch: select bit leads, byte follows MSB first
            d.ser_busy = 1'b1;
            d.sh = word;
            d.bits_left = 4'(SER_WORD_BITS);
            d.sdiv = 4'h0;
            d.link.cs_n = 1'b0;
            d.link.sclk = 1'b0;
            d.link.sdata = word[CMD_SEL_BIT];
            if (!word[CMD_SEL_BIT])
            begin
              // New command unit starts with its code
              d.cur_cmd = word[7:0];
              d.params_left = param_count(word[7:0]);
              d.param_idx = 5'h00;
              case (word[7:0])
                SLEEP_ENTER_CMD: d.sleeping = 1'b1;
                SLEEP_EXIT_CMD:
                begin
                  d.sleeping = 1'b0;
                  d.settle = 22'(SETTLE_CYC);
                end
                DISPLAY_OFF_CMD: d.disp_on = 1'b0;
                DISPLAY_ON_CMD: d.disp_on = 1'b1;
                default: d.disp_on = q.disp_on;
              endcase
            end
            else
            begin
              // Keep window limit bytes in order
              d.win = {q.win[15:0], word[7:0]};
              d.params_left = q.params_left - 5'h01;
              d.param_idx = q.param_idx + 5'h01;
            end
          end
        end
        OFS_STATUS:
        begin
          // Write one clears the refusal flag
          if (q.wstrb[0] && q.wdata[ST_REFUSED_BIT])
          begin
            d.refused = 1'b0;
          end
        end
        OFS_CTRL: d.video_en = (q.video_en & !q.wstrb[0]) | wr_val[0];
        OFS_COLOR: d.color = 18'((32'(q.color) & ~wmask) | wr_val);
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    // Write response taken: reopen both channels
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // Read channel: one read at a time
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CMD: d.rdata = {23'h000000, q.sh};
        OFS_STATUS: d.rdata = {11'h000, q.cur_cmd, q.params_left,
                               3'h0, q.refused,
                               q.settle != 22'h000000,
                               q.disp_on, q.sleeping, q.ser_busy};
        OFS_CTRL: d.rdata = {31'h00000000, q.video_en};
        OFS_COLOR: d.rdata = {14'h0000, q.color};
        default:
        begin
          d.rdata = 32'h00000000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // Serial shifter: change data on fall, device samples on rise
    if (q.ser_busy)
    begin
      if (q.sdiv == 4'(SCLK_HALF - 1))
      begin
        d.sdiv = 4'h0;
        if (!q.link.sclk)
        begin
          d.link.sclk = 1'b1;
          d.bits_left = q.bits_left - 4'h1;
        end
        else if (q.bits_left == 4'h0)
        begin
          // Last bit sampled: close the word
          d.link.sclk = 1'b0;
          d.link.cs_n = 1'b1;
          d.link.sdata = 1'b0;
          d.ser_busy = 1'b0;
        end
        else
        begin
          d.link.sclk = 1'b0;
          d.sh = {q.sh[7:0], 1'b0};
          d.link.sdata = q.sh[7];
        end
      end
      else
      begin
        d.sdiv = q.sdiv + 4'h1;
      end
    end

    // Pixel port: outputs move on the falling pixel clock edge
    if (!q.video_en)
    begin
      d.pix = ST_RESET.pix;
      d.pdiv = 4'h0;
      // Park on the last position so the first advance opens a frame
      d.hcnt = 10'(H_TOT - 1);
      d.vcnt = 10'(V_TOT - 1);
    end
    else if (q.pdiv == 4'(PCLK_HALF - 1))
    begin
      d.pdiv = 4'h0;
      d.pix.pclk = !q.pix.pclk;
      if (q.pix.pclk)
      begin
        nh = (q.hcnt == 10'(H_TOT - 1)) ? 10'h000 : q.hcnt + 10'h001;
        nv = q.vcnt;
        if (nh == 10'h000)
        begin
          nv = (q.vcnt == 10'(V_TOT - 1)) ? 10'h000 : q.vcnt + 10'h001;
        end
        hact = nh >= 10'(H_ACT0) && nh < 10'(H_ACT1);
        vact = nv >= 10'(V_ACT0) && nv < 10'(V_ACT1);
        d.hcnt = nh;
        d.vcnt = nv;
        d.pix.hsync_n = !(nh < 10'(LINE_SYNC));
        d.pix.vsync_n = !(nv < 10'(FRAME_SYNC));
        d.pix.de = hact && vact;
        d.pix.data = (hact && vact) ? q.color : 18'h00000;
      end
    end
    else
    begin
      d.pdiv = q.pdiv + 4'h1;
    end
  end

  // ==========================================================
  // State register, frozen while the clock enable is low
  // ==========================================================
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= ST_RESET;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign serial_link = q.link;
  assign pixel_port = q.pix;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_enable_in_active: assert property (
    q.pix.de |-> q.pix.hsync_n && q.pix.vsync_n && $past(q.video_en))
    else $error("enable outside active region");
  chk_sync_not_enable: assert property (
    $fell(q.pix.hsync_n) |-> !q.pix.de && q.hcnt == 10'h000)
    else $error("line sync start misplaced");
  chk_pixel_packing: assert property (
    q.pix.de |-> q.pix.data == q.color)
    else $error("pixel data not the fill colour");
  chk_sleep_after_off: assert property (
    $rose(q.ser_busy) && !q.sh[8] && q.sh[7:0] == SLEEP_ENTER_CMD
    |-> !q.disp_on)
    else $error("sleep-enter sent while display on");
  chk_on_after_settle: assert property (
    $rose(q.ser_busy) && !q.sh[8] && q.sh[7:0] == DISPLAY_ON_CMD
    |-> !q.sleeping && q.settle == 22'h000000)
    else $error("display-on sent too early");
  chk_gamma_value: assert property (
    $rose(q.ser_busy) && q.sh[8] && q.cur_cmd == GAMMA_CURVE_SELECT_CMD
    |-> q.sh[7:0] == GAMMA_CURVE_VALUE)
    else $error("gamma select parameter wrong");
  chk_param_budget: assert property (
    ce && !q.ser_busy ##1 $rose(q.ser_busy) && q.sh[8]
    |-> $past(q.params_left) != 5'h00)
    else $error("surplus parameter byte sent");
  chk_window_order: assert property (
    $rose(q.ser_busy) && q.sh[8] && q.param_idx == 5'h04 &&
    (q.cur_cmd == COLUMN_WINDOW_CMD || q.cur_cmd == ROW_WINDOW_CMD)
    |-> $past(q.win[23:8]) < q.win[15:0])
    else $error("window start not below end");
  chk_idle_clock_low: assert property (
    q.link.cs_n |-> !q.link.sclk && !q.ser_busy)
    else $error("serial clock active outside select");
  chk_word_opens_low: assert property (
    $fell(q.link.cs_n) |-> !q.link.sclk && q.link.sdata == q.sh[8])
    else $error("word does not open with select bit");

endmodule

`default_nettype wire

// *** tb/disp_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Panel model: serial command sink and pixel sink
// ==========================================================
module disp_panel_model (
  input wire disp_host_pkg::serial_link_t link,
  input wire disp_host_pkg::pixel_port_t pix,
  output int n_words,
  output logic [8:0] last_word,
  output int line_pix,
  output int n_lines,
  output logic [17:0] pix_data
);
  import disp_host_pkg::*;

  int nbits = 0;            // Bits seen in the current word
  logic [8:0] sh = '0;      // Select bit plus byte
  int pcnt = 0;             // Pixels seen in the current line
  logic asleep = 1'b1;      // Oscillator stopped after reset
  logic lit = 1'b0;         // Panel output off after reset
  logic [7:0] cmd = '0;     // Code of the current command unit
  int pidx = 0;             // Parameter bytes seen for that code
  logic [31:0] lim = '0;    // Last four parameter bytes, oldest first
  logic [15:0] col_lo = '0, col_hi = '0, row_lo = '0, row_hi = '0;
  logic [15:0] col = '0, row = '0; // RAM write address

  initial
  begin
    n_words = 0;
    last_word = '0;
    line_pix = 0;
    n_lines = 0;
    pix_data = '0;
  end

  // Each select starts a fresh word
  always @(negedge link.cs_n)
    nbits = 0;

  // Sample data at serial clock rise, select bit first, MSB first
  always @(posedge link.sclk)
    if (!link.cs_n)
    begin
      sh = {sh[7:0], link.sdata};
      nbits++;
    end

  // Decode a whole word when select is released; unknown codes do nothing
  always @(posedge link.cs_n)
    if (nbits == SER_WORD_BITS)
    begin
      n_words++;
      last_word = sh;
      if (!sh[8])
      begin
        cmd = sh[7:0];
        pidx = 0;
        case (sh[7:0])
          8'h10: asleep = 1'b1;
          8'h11: asleep = 1'b0;
          8'h28: lit = 1'b0;
          8'h29: lit = 1'b1;
          default: ;
        endcase
      end
      else
      begin
        // Window limits take effect on the fourth byte
        lim = {lim[23:0], sh[7:0]};
        pidx++;
        if (pidx == 4 && cmd == 8'h2A)
        begin
          col_lo = lim[31:16];
          col_hi = lim[15:0];
          col = lim[31:16];
        end
        if (pidx == 4 && cmd == 8'h2B)
        begin
          row_lo = lim[31:16];
          row_hi = lim[15:0];
          row = lim[31:16];
        end
      end
    end

  // Capture pixels only while enable is high; close a line when it drops
  always @(posedge pix.pclk)
    if (pix.de)
    begin
      pcnt++;
      pix_data = pix.data;
      // Address walk: past the end column, reload start and bump row
      if (col >= col_hi)
      begin
        col = col_lo;
        row = (row >= row_hi) ? row_lo : row + 16'h0001;
      end
      else
        col = col + 16'h0001;
    end
    else if (pcnt != 0)
    begin
      line_pix = pcnt;
      n_lines++;
      pcnt = 0;
    end
endmodule

`default_nettype wire

// *** tb/test_display_command_and_pixel_port.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_display_command_and_pixel_port;
  import disp_host_pkg::*;

  // ==========================================================
  // Stimulus and observation signals
  // ==========================================================
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  serial_link_t link;
  pixel_port_t pix;
  int n_words, line_pix, n_lines;
  logic [8:0] last_word;
  logic [17:0] pix_data, pcol;
  int n_errors = 0, checks = 0, seed = 13, cyc = 0;
  // Reference model of the host's view of the panel
  int sent = 0, left = 0, idx = 0;
  logic [8:0] exp_word = '0;
  logic sleeping = 1'b1, disp_on = 1'b0;
  logic hs_lo = 1'b0, vs_lo = 1'b0;
  logic [7:0] cur = '0, pb;
  logic [7:0] wp [4];
  logic [7:0] codes [24] = '{8'h10, 8'h11, 8'h26, 8'h28, 8'h29, 8'h2A,
    8'h2B, 8'h36, 8'h3A, 8'h5B, 8'h70, 8'h8A, 8'hB0, 8'hB1, 8'hB2, 8'hB8,
    8'hC0, 8'hC1, 8'hCC, 8'hCD, 8'hCE, 8'hD0, 8'hF0, 8'hF1};
  int cnts [24] = '{0, 0, 1, 0, 0, 4, 4, 1, 1, 1, 1, 1, 20, 19, 6, 3, 13,
    13, 1, 1, 1, 1, 1, 1};

  always #50 clk_sys = ~clk_sys;

  disp_host_ctrl #(.SETTLE_CYC(20), .ROWS(2)) disp_host_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_link(link), .pixel_port(pix));

  disp_panel_model disp_panel_model_i (
    .link(link), .pix(pix), .n_words(n_words), .last_word(last_word),
    .line_pix(line_pix), .n_lines(n_lines), .pix_data(pix_data));

  // ==========================================================
  // Verdict, comparison and bus tasks
  // ==========================================================
  task automatic conclude;
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Handshakes are judged at the falling edge, acted on at the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok)
    begin
      @(negedge clk_sys);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rsp = bresp;
      @(posedge clk_sys);
      if (aw_ok)
        awvalid <= 1'b0;
      if (w_ok)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic a_ok, r_ok;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok)
    begin
      @(negedge clk_sys);
      a_ok = arvalid && arready;
      r_ok = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk_sys);
      if (a_ok)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Send one serial word, predicting refusal and the panel's state
  task automatic send(input logic sel, input logic [7:0] b);
    logic refuse;
    refuse = 1'b0;
    if (!sel)
      refuse = (b == 8'h10 && disp_on) || (b == 8'h29 && sleeping);
    else if (left == 0)
      refuse = 1'b1;
    else if (cur == 8'h26 && b != 8'h01)
      refuse = 1'b1;
    else if (cur[7:1] == 7'h15 && idx == 3)
      refuse = {wp[0], wp[1]} >= {wp[2], b};
    if (!refuse && !sel)
    begin
      cur = b;
      idx = 0;
      left = 0;
      for (int i = 0; i < 24; i++)
        if (codes[i] == b)
          left = cnts[i];
      if (b == 8'h10) sleeping = 1'b1;
      if (b == 8'h11) sleeping = 1'b0;
      if (b == 8'h28) disp_on = 1'b0;
      if (b == 8'h29) disp_on = 1'b1;
    end
    else if (!refuse)
    begin
      if (idx < 4)
        wp[idx] = b;
      idx++;
      left--;
    end
    if (!refuse)
    begin
      sent++;
      exp_word = {sel, b};
    end
    wr(OFS_CMD, {23'h0, sel, b});
    rd_reg(OFS_STATUS);
    while (rd[0] || rd[3])
      rd_reg(OFS_STATUS);
    check(n_words == sent && last_word === exp_word, "serial word");
    check(rd[4] === refuse, "refusal flag");
    check(rd[2:1] === {disp_on, sleeping}, "panel state");
    check(disp_panel_model_i.asleep === sleeping &&
          disp_panel_model_i.lit === disp_on, "model state");
    if (rd[4])
      wr(OFS_STATUS, 32'h10);
  endtask

  // Bound on the whole run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_errors++;
      conclude;
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(OFS_STATUS);
    check(rd === 32'h2 && rsp === RESP_OKAY, "status at reset");
    rd_reg(8'h10);
    check(rd === 32'h0 && rsp === RESP_SLVERR, "unmapped read");
    wr(8'h14, 32'h0);
    check(rsp === RESP_SLVERR, "unmapped write");
    send(1'b0, 8'h29);
    send(1'b1, 8'h00);
    send(1'b0, 8'h77);
    send(1'b1, 8'h55);
    // Every listed code with its full parameter count
    for (int c = 0; c < 24; c++)
    begin
      send(1'b0, codes[c]);
      for (int p = 0; p < cnts[c]; p++)
      begin
        pb = 8'($random(seed));
        if (codes[c] == 8'h26)
          pb = 8'h01;
        if (codes[c][7:1] == 7'h15)
          pb = (p == 3) ? 8'hEF : 8'h00;
        send(1'b1, pb);
      end
    end
    send(1'b1, 8'h01);
    send(1'b0, 8'h10);
    send(1'b0, 8'h28);
    send(1'b0, 8'h10);
    send(1'b0, 8'h11);
    send(1'b0, 8'h26);
    send(1'b1, 8'h02);
    send(1'b0, 8'h2B);
    send(1'b1, 8'h00);
    send(1'b1, 8'h10);
    send(1'b1, 8'h00);
    send(1'b1, 8'h05);
    // Two-row window so the second line wraps the row
    send(1'b0, 8'h2B);
    for (int p = 0; p < 4; p++)
      send(1'b1, (p == 3) ? 8'h01 : 8'h00);
    // Pixel port: fill colour over whole lines
    pcol = 18'($random(seed));
    wr(OFS_COLOR, {14'h0, pcol});
    rd_reg(OFS_COLOR);
    check(rd === {14'h0, pcol}, "colour readback");
    wr(OFS_CTRL, 32'h1);
    while (n_lines < 1)
    begin
      @(posedge clk_sys);
      hs_lo |= !pix.hsync_n;
      vs_lo |= !pix.vsync_n;
    end
    check(hs_lo === 1'b1 && vs_lo === 1'b1, "syncs never low");
    check(disp_panel_model_i.col === 16'h0000 &&
          disp_panel_model_i.row === 16'h0001, "column wrap");
    while (n_lines < 2)
      @(posedge clk_sys);
    check(disp_panel_model_i.col === 16'h0000 &&
          disp_panel_model_i.row === 16'h0000, "row wrap");
    check(line_pix == 240, "pixels per line");
    check(pix_data === pcol, "pixel packing");
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(pix.de === 1'b0 && pix.hsync_n === 1'b1, "pixel stop");
    check(pix.vsync_n === 1'b1, "frame sync idle");
    conclude;
  end
endmodule

`default_nettype wire
